/* pkg/ldc_pkg.sv */
// Constants shared by the LED driver control register block
`default_nettype none
package ldc_pkg;
  // Register addresses within the serial frame
  localparam logic [5:0]  ADDR_MON_WD_CTRL   = 6'h01;
  localparam logic [5:0]  ADDR_DITHER_CTRL   = 6'h02;
  // Values after reset, and the mask of stored bits in the first register
  localparam logic [15:0] MON_WD_CTRL_RESET  = 16'h000e;
  localparam logic [15:0] DITHER_CTRL_RESET  = 16'h5e1f;
  localparam logic [15:0] MON_WD_CTRL_MASK   = 16'h003f;
  // Field positions, monitor and watchdog control
  localparam int          MON_SEL_LSB        = 4;
  localparam int          MON_EN_BIT         = 3;
  localparam int          FOLD_EN_BIT        = 2;
  localparam int          WD_SEL_BIT         = 1;
  localparam int          WD_KICK_BIT        = 0;
  // Field positions, dither and current control
  localparam int          DEV_LSB            = 13;
  localparam int          RATE_LSB           = 11;
  localparam int          DITH_EN_BIT        = 10;
  localparam int          LED_TRIM_LSB       = 5;
  localparam int          IN_LIM_LSB         = 0;
  // Monitor select encodings
  localparam logic [1:0]  MON_PWM            = 2'h0;
  localparam logic [1:0]  MON_LED_VOLT       = 2'h1;
  localparam logic [1:0]  MON_THERM          = 2'h2;
  localparam logic [1:0]  MON_LIGHT_MODE     = 2'h3;
  // Operation codes
  localparam logic [1:0]  OP_WRITE           = 2'h0;
  // Frame length in serial clocks, and header length
  localparam logic [4:0]  FRAME_BITS         = 5'h18;
  localparam logic [4:0]  HEADER_BITS        = 5'h08;
  // Watchdog intervals in ms and the system clock rate in kHz
  localparam int          WD_SHORT_MS        = 10;
  localparam int          WD_LONG_MS         = 50;
  localparam int          CLK_KHZ            = 40000;
  // Watchdog intervals in whole cycles, ms times kHz
  localparam int          WD_SHORT_CYC       = WD_SHORT_MS * CLK_KHZ;
  localparam int          WD_LONG_CYC        = WD_LONG_MS * CLK_KHZ;
  // Synchroniser input count
  localparam int          SYNC_W             = 7;
endpackage
`default_nettype wire

/* hdl/ldc_sync.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module ldc_sync #(
  parameter int WIDTH = 1                  // Number of pins
) (
  input  wire logic             clk_sys,   // System clock
  input  wire logic             resetn,    // Async reset, active low
  input  wire logic             ce,        // Clock enable
  input  wire logic [WIDTH-1:0] pin_in,    // Raw pins
  output logic      [WIDTH-1:0] level      // Filtered level
);
  logic [WIDTH-1:0] s1;                    // First stage, read by s2 only
  logic [WIDTH-1:0] s2;                    // Second stage
  logic [WIDTH-1:0] s3;                    // Third stage

  // Shift chain; the first stage feeds nothing but the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a change only once two stages agree, per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_agree
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          level[i] <= 1'b0;
        end else if (ce && (s2[i] == s3[i])) begin
          level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule // ldc_sync
`default_nettype wire

/* hdl/ldc_ctrl_regs.sv */
// Monitor, fold-back, watchdog and dither control registers behind serial port
//
// Overview of operation
// - First control register resets to 000e hex.
// - Select 00 routes dimming, 01 chain voltage.
// - Select 10 routes thermistor signal to monitor.
// - Select 11 routes light-mode pin to monitor.
// - Fold-back bit enables current cut when hot.
// - Limp mode ignores fold-back bit; monitoring stays.
`default_nettype none
module ldc_ctrl_regs
  import ldc_pkg::*;
#(
  parameter int WD_SHORT_CYCLES = WD_SHORT_CYC,  // Short watchdog interval
  parameter int WD_LONG_CYCLES  = WD_LONG_CYC    // Long watchdog interval
) (
  input  wire logic       clk_sys,            // 40 MHz system clock
  input  wire logic       resetn,             // Async reset, active low
  input  wire logic       ce,                 // Clock enable, freezes state
  input  wire logic       spi_cs_n,           // Serial chip select, low
  input  wire logic       spi_sck,            // Serial clock pin
  input  wire logic       spi_sdi,            // Serial data in
  output logic            spi_sdo,            // Serial data out
  output logic            spi_sdo_oe,         // Data out driven, high
  input  wire logic [7:0] status_byte,        // Global status from device
  input  wire logic       pwm_in,             // Dimming input pin
  input  wire logic       led_chain_voltage,  // Chain voltage comparator
  input  wire logic       thermistor_in,      // Thermistor signal
  input  wire logic       light_mode_in,      // Light-mode pin
  input  wire logic       over_temp,          // LED over-temperature, same clk
  input  wire logic       limp_mode,          // Any limp mode, same clk
  output logic            monitor_out,        // Multiplexed monitor pin
  output logic            fold_back_active,   // Reduce LED current
  output logic            thermal_monitor_on, // Temperature monitor active
  output logic            watchdog_timeout,   // Watchdog expired, sticky
  output logic [2:0]      dither_deviation,   // Dither deviation code
  output logic [1:0]      dither_rate,        // Dither modulation rate
  output logic            dither_enable,      // Dither on
  output logic [4:0]      led_current_trim,   // LED current setting
  output logic [4:0]      input_current_limit // Input current limit
);
  logic [SYNC_W-1:0] pins;          // Filtered pin levels
  logic        cs_n_s;              // Filtered chip select
  logic        sck_s;               // Filtered serial clock
  logic        sdi_s;               // Filtered data in
  logic        cs_prev;             // Chip select last cycle
  logic        sck_prev;            // Serial clock last cycle
  logic        sck_rise;            // Sampling edge
  logic        sck_fall;            // Shifting edge
  logic        cs_fall;             // Frame start
  logic        cs_rise;             // Frame end
  logic [4:0]  bit_cnt;             // Bits taken this frame
  logic [23:0] shift_in;            // Received frame
  logic [7:0]  status_cap;          // Status held for the frame
  logic [15:0] data_cap;            // Addressed register content
  logic [15:0] mon_wd_ctrl;         // First control register
  logic [15:0] dither_ctrl;         // Second control register
  logic        frame_write;         // Valid write at frame end
  logic        kick;                // Kick bit toggled by a write
  logic [31:0] wd_cnt;              // Watchdog cycle counter
  logic [31:0] wd_limit;            // Selected interval in cycles
  logic        wd_expire;           // Count has reached the interval
  logic [23:0] reply;               // Status and content, MSB first

  // Pins from outside the clock domain pass the filter; select enters
  // inverted so the filter's reset level matches an idle bus
  ldc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .pin_in  ({!spi_cs_n, spi_sck, spi_sdi, pwm_in, led_chain_voltage,
               thermistor_in, light_mode_in}),
    .level   (pins)
  );

  assign cs_n_s   = !pins[6];
  assign reply    = {status_cap, data_cap};
  assign sck_s    = pins[5];
  assign sdi_s    = pins[4];
  assign sck_rise = !cs_n_s && sck_s && !sck_prev;
  assign sck_fall = !cs_n_s && !sck_s && sck_prev;
  assign cs_fall  = cs_prev && !cs_n_s;
  assign cs_rise  = !cs_prev && cs_n_s;

  // Register read decode; unmapped addresses read zero
  function automatic logic [15:0] reg_read(input logic [5:0] addr,
                                           input logic [15:0] r1,
                                           input logic [15:0] r2);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == ADDR_MON_WD_CTRL) begin
      v = r1;
    end else if (addr == ADDR_DITHER_CTRL) begin
      v = r2;
    end
    reg_read = v;
  endfunction

  // Edge history of the filtered serial pins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cs_prev  <= 1'b1;
      sck_prev <= 1'b0;
    end else if (ce) begin
      cs_prev  <= cs_n_s;
      sck_prev <= sck_s;
    end
  end

  // Receive side: count and shift on rising serial clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bit_cnt  <= 5'h00;
      shift_in <= 24'h000000;
    end else if (ce) begin
      if (cs_fall) begin
        bit_cnt <= 5'h00;
      end else if (sck_rise) begin
        shift_in <= {shift_in[22:0], sdi_s};
        // Saturate so an overlong frame stays invalid
        if (bit_cnt != 5'h1f) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // Reply capture: status at frame start, old content after header
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_cap <= 8'h00;
      data_cap   <= 16'h0000;
    end else if (ce) begin
      if (cs_fall) begin
        status_cap <= status_byte;
        data_cap   <= 16'h0000;
      end else if (sck_rise && bit_cnt == HEADER_BITS - 5'h01) begin
        // Address bits complete with this edge
        data_cap <= reg_read({shift_in[4:0], sdi_s}, mon_wd_ctrl,
                             dither_ctrl);
      end
    end
  end

  // Transmit side: first bit at select fall, next on each falling clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (ce) begin
      spi_sdo_oe <= !cs_n_s;
      if (cs_fall) begin
        spi_sdo <= status_byte[7];
      end else if (sck_fall && bit_cnt < FRAME_BITS) begin
        // Bits already taken point at the next reply bit
        spi_sdo <= reply[5'd23 - bit_cnt];
      end else if (cs_n_s) begin
        spi_sdo <= 1'b0;
      end
    end
  end

  // Only a frame of exactly the full length commits a write
  assign frame_write = cs_rise && bit_cnt == FRAME_BITS
                       && shift_in[23:22] == OP_WRITE;
  assign kick = frame_write && shift_in[21:16] == ADDR_MON_WD_CTRL
                && shift_in[WD_KICK_BIT] != mon_wd_ctrl[WD_KICK_BIT];

  // First control register; reserved bits are not stored
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mon_wd_ctrl <= MON_WD_CTRL_RESET;
    end else if (ce && frame_write
                 && shift_in[21:16] == ADDR_MON_WD_CTRL) begin
      mon_wd_ctrl <= shift_in[15:0] & MON_WD_CTRL_MASK;
    end
  end

  // Second control register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dither_ctrl <= DITHER_CTRL_RESET;
    end else if (ce && frame_write
                 && shift_in[21:16] == ADDR_DITHER_CTRL) begin
      dither_ctrl <= shift_in[15:0];
    end
  end

  assign dither_deviation    = dither_ctrl[DEV_LSB +: 3];
  assign dither_rate         = dither_ctrl[RATE_LSB +: 2];
  assign dither_enable       = dither_ctrl[DITH_EN_BIT];
  assign led_current_trim    = dither_ctrl[LED_TRIM_LSB +: 5];
  assign input_current_limit = dither_ctrl[IN_LIM_LSB +: 5];

  // Monitor multiplexer, held low while monitor output is disabled
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      monitor_out <= 1'b0;
    end else if (ce) begin
      if (!mon_wd_ctrl[MON_EN_BIT]) begin
        monitor_out <= 1'b0;
      end else begin
        unique case (mon_wd_ctrl[MON_SEL_LSB +: 2])
          MON_PWM:        monitor_out <= pins[3];
          MON_LED_VOLT:   monitor_out <= pins[2];
          MON_THERM:      monitor_out <= pins[1];
          MON_LIGHT_MODE: monitor_out <= pins[0];
        endcase
      end
    end
  end

  // Thermal fold-back; limp mode forces monitoring on regardless
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fold_back_active   <= 1'b0;
      thermal_monitor_on <= 1'b0;
    end else if (ce) begin
      thermal_monitor_on <= mon_wd_ctrl[FOLD_EN_BIT] || limp_mode;
      fold_back_active   <= (mon_wd_ctrl[FOLD_EN_BIT] || limp_mode)
                            && over_temp;
    end
  end

  assign wd_limit = mon_wd_ctrl[WD_SEL_BIT] ? 32'(WD_LONG_CYCLES)
                                            : 32'(WD_SHORT_CYCLES);
  assign wd_expire = wd_cnt >= wd_limit - 32'h00000001;

  // Watchdog: a kick toggle restarts the count; timeout stays until kicked
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wd_cnt           <= 32'h00000000;
      watchdog_timeout <= 1'b0;
    end else if (ce) begin
      // Expiry in the kick cycle still sets the flag; the set wins
      if (wd_expire && !watchdog_timeout) begin
        watchdog_timeout <= 1'b1;
      end else if (kick) begin
        watchdog_timeout <= 1'b0;
      end
      // Count stalls at expiry so the flag cannot wrap away
      if (kick) begin
        wd_cnt <= 32'h00000000;
      end else if (!wd_expire) begin
        wd_cnt <= wd_cnt + 32'h00000001;
      end
    end
  end
endmodule // ldc_ctrl_regs
`default_nettype wire

/* verif/ldc_ctrl_regs_props.sv */
// Port checker for the LED driver control register block
`default_nettype none
module ldc_ctrl_regs_props (
  input wire logic clk_sys,           // System clock
  input wire logic resetn,            // Async reset, active low
  input wire logic ce,                // Clock enable
  input wire logic pwm_in,            // Dimming pin
  input wire logic led_chain_voltage, // Chain voltage level
  input wire logic thermistor_in,     // Thermistor signal
  input wire logic light_mode_in,     // Light-mode pin
  input wire logic over_temp,         // LED over-temperature
  input wire logic limp_mode,         // Any limp mode
  input wire logic monitor_out,       // Monitor pin
  input wire logic fold_back_active,  // Current cut request
  input wire logic thermal_monitor_on // Temperature monitor active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Every monitor source low, long enough to pass the filter
  sequence pins_low;
    (ce && !pwm_in && !led_chain_voltage && !thermistor_in
     && !light_mode_in)[*8];
  endsequence
  // Limp mode while hot, clock running
  sequence limp_hot;
    limp_mode && over_temp && ce;
  endsequence
  a_boot_monitor_on: assert property (
    !$past(resetn) && ce |=> thermal_monitor_on)
    else $error("monitor off after reset");
  a_limp_monitor_on: assert property (
    limp_mode && ce |=> thermal_monitor_on)
    else $error("limp mode lost monitoring");
  a_limp_fold_on: assert property (
    limp_hot |=> fold_back_active)
    else $error("limp mode ignored heat");
  a_cool_no_fold: assert property (
    !over_temp && ce |=> !fold_back_active)
    else $error("fold back without heat");
  a_fold_needs_mon: assert property (
    fold_back_active |-> thermal_monitor_on)
    else $error("fold back while disabled");
  a_mux_low_pins: assert property (
    pins_low |-> !monitor_out)
    else $error("monitor high with sources low");
endmodule // ldc_ctrl_regs_props
bind ldc_ctrl_regs ldc_ctrl_regs_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .pwm_in(pwm_in),
  .led_chain_voltage(led_chain_voltage), .thermistor_in(thermistor_in),
  .light_mode_in(light_mode_in), .over_temp(over_temp),
  .limp_mode(limp_mode), .monitor_out(monitor_out),
  .fold_back_active(fold_back_active),
  .thermal_monitor_on(thermal_monitor_on));
`default_nettype wire

/* verif/ldc_host_model.sv */
// Host controller model driving the serial port
`default_nettype none
module ldc_host_model (
  input  wire logic clk_sys,  // System clock
  output logic      spi_cs_n, // Chip select, low
  output logic      spi_sck,  // Serial clock, still between frames
  output logic      spi_sdi,  // Serial data to device
  input  wire logic spi_sdo   // Serial data from device
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8; // Half period, well above filter delay
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_sdi  = 1'b0;
  end
  // Idle data line toggles, so a stale bit is never trusted
  always @(posedge clk_sys) if (spi_cs_n) spi_sdi <= #1 ~spi_sdi;
  // Wait n edges, then step just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One 24-bit frame, MSB first; reply sampled before each rise
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
    step(1);
    spi_cs_n = 1'b0;
    step(HALF);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = tx[i];
      step(HALF);
      rx[i]   = spi_sdo;
      spi_sck = 1'b1;
      step(HALF);
      spi_sck = 1'b0;
    end
    step(HALF);
    spi_cs_n = 1'b1;
    step(16);
  endtask
endmodule // ldc_host_model
`default_nettype wire

/* verif/led_driver_control_regs_tb_top.sv */
// Self-checking bench for the LED driver control register block
`default_nettype none
module led_driver_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ldc_pkg::*;
  localparam int WD_S = 1000; // Shortened watchdog intervals
  localparam int WD_L = 3000;
  logic        clk_sys, resetn, ce, cs_n, sck, sdi, sdo, sdo_oe;
  logic [7:0]  status_byte;  // Status fed to the reply
  logic [3:0]  pins;         // Sources in select order
  logic        over_temp, limp_mode, mon, fold, therm, wdt;
  logic [2:0]  dev;
  logic [1:0]  rate;
  logic        dith;
  logic [4:0]  trim, ilim;
  logic [15:0] r1 = 16'h000e; // Register model
  logic [15:0] r2 = 16'h5e1f;
  logic [23:0] rx;            // Last reply
  int          n_errors = 0;
  int          check_count = 0;
  ldc_ctrl_regs #(.WD_SHORT_CYCLES(WD_S), .WD_LONG_CYCLES(WD_L)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .spi_cs_n(cs_n),
    .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .status_byte(status_byte), .pwm_in(pins[0]),
    .led_chain_voltage(pins[1]), .thermistor_in(pins[2]),
    .light_mode_in(pins[3]), .over_temp(over_temp), .limp_mode(limp_mode),
    .monitor_out(mon), .fold_back_active(fold), .thermal_monitor_on(therm),
    .watchdog_timeout(wdt), .dither_deviation(dev), .dither_rate(rate),
    .dither_enable(dith), .led_current_trim(trim),
    .input_current_limit(ilim));
  ldc_host_model u_host (.clk_sys(clk_sys), .spi_cs_n(cs_n), .spi_sck(sck),
    .spi_sdi(sdi), .spi_sdo(sdo));
  // Free-running 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One frame; reply is status then old content, then model updates
  task automatic xfer(input logic [1:0] op, input logic [5:0] a,
                      input logic [15:0] d);
    logic [15:0] old;
    // Every op reads back the addressed content
    old = (a == ADDR_MON_WD_CTRL) ? r1 :
          (a == ADDR_DITHER_CTRL) ? r2 : 16'h0000;
    status_byte = 8'($urandom);
    if (op == OP_WRITE && a == ADDR_MON_WD_CTRL) d[0] = ~r1[0];
    u_host.frame({op, a, d}, rx);
    check(rx, {status_byte, old});
    if (op == OP_WRITE && a == ADDR_MON_WD_CTRL) r1 = d & MON_WD_CTRL_MASK;
    if (op == OP_WRITE && a == ADDR_DITHER_CTRL) r2 = d;
    step(2);
  endtask
  // Outputs against the model
  task automatic outs;
    check({dev, rate, dith, trim, ilim}, r2);
    check(therm, r1[FOLD_EN_BIT] | limp_mode);
    check(fold, (r1[FOLD_EN_BIT] | limp_mode) & over_temp);
    check(mon, r1[MON_EN_BIT] ? pins[r1[5:4]] : 1'b0);
  endtask
  // Main sequence: reset values, every op, mux and fold grid, watchdog
  initial begin
    ce = 1'b1;
    resetn = 1'b0;
    status_byte = 8'h00;
    pins = 4'h0;
    over_temp = 1'b0;
    limp_mode = 1'b0;
    void'($urandom(32'h0b87));
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    step(2);
    outs();
    xfer(2'h1, ADDR_MON_WD_CTRL, 16'h0000);
    xfer(2'h1, ADDR_DITHER_CTRL, 16'h0000);
    xfer(2'h1, 6'h03, 16'h0000);
    for (int op = 0; op < 4; op++) xfer(2'(op), ADDR_MON_WD_CTRL, 16'hffca);
    // Select, enable and fold bit over all sixteen mixes
    for (int s = 0; s < 16; s++) begin
      xfer(OP_WRITE, ADDR_MON_WD_CTRL, {10'h000, s[1:0], ~s[3], s[2], 2'h2});
      repeat (4) begin
        pins = 4'($urandom);
        {limp_mode, over_temp} = 2'($urandom);
        step(8);
        outs();
      end
    end
    repeat (3) begin
      xfer(OP_WRITE, ADDR_DITHER_CTRL, 16'($urandom));
      outs();
    end
    // Clock enable low freezes the fold flag while heat rises
    {limp_mode, over_temp} = 2'h0;
    step(2);
    ce = 1'b0;
    over_temp = 1'b1;
    step(8);
    check(fold, 1'b0);
    ce = 1'b1;
    step(2);
    check(fold, r1[FOLD_EN_BIT]);
    // Short interval: quiet before expiry, sticky after, kick clears
    xfer(OP_WRITE, ADDR_MON_WD_CTRL, 16'h0008);
    step(WD_S - 100);
    check(wdt, 1'b0);
    step(200);
    check(wdt, 1'b1);
    xfer(OP_WRITE, ADDR_MON_WD_CTRL, 16'h0008);
    check(wdt, 1'b0);
    conclude();
  end
  // Hang guard, far beyond the expected run
  initial begin
    #2_000_000;
    n_errors++;
    conclude();
  end
endmodule // led_driver_control_regs_tb_top
`default_nettype wire
